// >>> epas_pkg.sv
// Constants and types for the external port access sequencer
package epas_pkg;

	// ==========================================================
	// Widths
	localparam int EPAS_ADDR_W = 22;
	localparam int EPAS_DATA_W = 16;
	localparam int EPAS_SEL_W = 2;
	localparam int EPAS_CS_W = 4;
	localparam int EPAS_DIV_W = 3;
	localparam int EPAS_WAIT_W = 4;
	localparam int EPAS_PH_W = 4;
	localparam int EPAS_LEN_W = 6;

	// ==========================================================
	// Reset values and codes
	localparam logic [EPAS_CS_W-1:0] EPAS_CS_IDLE = 4'hF;
	localparam logic [EPAS_CS_W-1:0] EPAS_CS_ONE = 4'h1;
	localparam logic [EPAS_ADDR_W-1:0] EPAS_ADDR_RST = 22'h000000;
	localparam logic [EPAS_DATA_W-1:0] EPAS_DATA_RST = 16'h0000;
	localparam logic [EPAS_WAIT_W-1:0] EPAS_WAIT_ZERO = 4'h0;
	localparam logic [EPAS_PH_W-1:0] EPAS_PH_ZERO = 4'h0;
	localparam logic [EPAS_PH_W-1:0] EPAS_PH_ONE = 4'h1;

	// Wait mode bits
	localparam int EPAS_MODE_WAIT_BIT = 0;
	localparam int EPAS_MODE_READY_BIT = 1;

	// ==========================================================
	// Write data hold, in peripheral clock cycles after strobe end
	localparam logic [1:0] EPAS_HOLD_BASE = 2'h1;
	localparam logic [1:0] EPAS_HOLD_EXT = 2'h2;

	// Read buffer depth
	localparam logic [1:0] EPAS_BUF_DEPTH = 2'h2;

	// ==========================================================
	// Access sequencer states
	typedef enum logic [3:0] {
		EPAS_IDLE = 4'h1,
		EPAS_SETUP = 4'h2,
		EPAS_STROBE = 4'h4,
		EPAS_HOLD = 4'h8
	} epas_state_t;

endpackage

// >>> epas_stream_if.sv
// Valid/ready word carrier between the sequencer and its read buffer
`timescale 1ns/1ns
`default_nettype none
interface epas_stream_if
	import epas_pkg::*;
;
	logic valid;
	logic ready;
	logic [EPAS_DATA_W-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> epas_buf2.sv
// Two-entry read data buffer
`timescale 1ns/1ns
`default_nettype none
module epas_buf2
	import epas_pkg::*;
(
	input wire logic mclk_in, // Peripheral clock
	input wire logic rst_b_in, // Async reset, active low
	epas_stream_if.sink fill, // Words in
	epas_stream_if.source drain // Words out
);

	logic [EPAS_DATA_W-1:0] mem_ff [EPAS_BUF_DEPTH];
	logic wp_ff, nxt_wp;
	logic rp_ff, nxt_rp;
	logic [1:0] cnt_ff, nxt_cnt;
	logic push, pop;

	assign fill.ready = (cnt_ff != EPAS_BUF_DEPTH);
	assign drain.valid = (cnt_ff != 2'h0);
	assign drain.data = mem_ff[rp_ff];

	always_comb begin
		push = fill.valid && fill.ready;
		pop = drain.valid && drain.ready;
		nxt_wp = wp_ff ^ push;
		nxt_rp = rp_ff ^ pop;
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 2'h1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 2'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wp_ff <= 1'b0;
			rp_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	// Storage needs no reset; count guards reads
	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem_ff[wp_ff] <= fill.data;
		end
	end

endmodule
`default_nettype wire

// >>> epas_port_seq.sv
// External port access sequencer top
`timescale 1ns/1ns
`default_nettype none
module epas_port_seq
	import epas_pkg::*;
(
	input wire logic mclk_in, // Peripheral clock
	input wire logic rst_b_in, // Async reset, active low
	input wire logic [EPAS_DIV_W-1:0] port_div_in, // Port clock half period minus one
	input wire logic [1:0] wait_mode_in, // Bit0 wait states, bit1 ready
	input wire logic [EPAS_WAIT_W-1:0] wait_states_in, // Programmed wait states
	input wire logic write_hold_extend_in, // Longer write data hold
	input wire logic req_valid_in, // Access request
	output logic req_ready_out, // Request taken
	input wire logic req_write_in, // 1 write, 0 read
	input wire logic [EPAS_SEL_W-1:0] req_sel_in, // Memory select index
	input wire logic [EPAS_ADDR_W-1:0] req_addr_in, // Access address
	input wire logic [EPAS_DATA_W-1:0] req_wdata_in, // Write data
	output logic rd_valid_out, // Read word available
	input wire logic rd_ready_in, // Read word consumed
	output logic [EPAS_DATA_W-1:0] rd_data_out, // Read word
	output logic [EPAS_CS_W-1:0] memory_select_n_out, // Chip selects, active low
	output logic [EPAS_ADDR_W-1:0] addr_out, // Address pins
	output logic rd_n_out, // Read strobe, active low
	output logic wr_n_out, // Write strobe, active low
	output logic [EPAS_DATA_W-1:0] data_out, // Data pins out
	output logic data_oe_out, // Data pins driven
	input wire logic [EPAS_DATA_W-1:0] data_in, // Data pins in
	input wire logic ready_in // External ready, low to wait
);

	// ==========================================================
	// Port clock phase
	logic [EPAS_PH_W-1:0] phase_ff, nxt_phase;
	logic [EPAS_PH_W-1:0] half_cnt, last_ph;
	logic rise_tick, fall_tick;

	always_comb begin
		half_cnt = {1'b0, port_div_in} + EPAS_PH_ONE;
		last_ph = {port_div_in, 1'b1};
		rise_tick = (phase_ff == EPAS_PH_ZERO);
		fall_tick = (phase_ff == half_cnt);
		nxt_phase = (phase_ff >= last_ph) ? EPAS_PH_ZERO : phase_ff + EPAS_PH_ONE;
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase_ff <= EPAS_PH_ZERO;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// ==========================================================
	// Read buffer
	epas_stream_if fill_if ();
	epas_stream_if drain_if ();

	epas_buf2 u_buf (
		.mclk_in (mclk_in),
		.rst_b_in (rst_b_in),
		.fill (fill_if.sink),
		.drain (drain_if.source)
	);

	assign drain_if.ready = rd_ready_in;
	assign rd_valid_out = drain_if.valid;
	assign rd_data_out = drain_if.data;

	// ==========================================================
	// Access sequencer
	epas_state_t st_ff, nxt_st;
	logic [EPAS_CS_W-1:0] cs_ff, nxt_cs;
	logic [EPAS_ADDR_W-1:0] addr_ff, nxt_addr;
	logic [EPAS_DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [EPAS_DATA_W-1:0] rdata_ff, nxt_rdata;
	logic [EPAS_WAIT_W-1:0] wcnt_ff, nxt_wcnt;
	logic wr_ff, nxt_wr;
	logic rd_n_ff, nxt_rd_n;
	logic wr_n_ff, nxt_wr_n;
	logic go_ff, nxt_go;
	logic push_ff, nxt_push;
	logic stall_now;

	assign req_ready_out = (st_ff == EPAS_IDLE) && fall_tick && fill_if.ready;
	assign fill_if.valid = push_ff;
	assign fill_if.data = rdata_ff;
	assign memory_select_n_out = cs_ff;
	assign addr_out = addr_ff;
	assign rd_n_out = rd_n_ff;
	assign wr_n_out = wr_n_ff;
	assign data_out = wdata_ff;

	always_comb begin
		nxt_st = st_ff;
		nxt_cs = cs_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_wcnt = wcnt_ff;
		nxt_wr = wr_ff;
		nxt_rd_n = rd_n_ff;
		nxt_wr_n = wr_n_ff;
		nxt_go = go_ff;
		nxt_push = 1'b0;
		stall_now = wait_mode_in[EPAS_MODE_READY_BIT] && !ready_in;
		case (st_ff)
			EPAS_IDLE: begin
				if (req_valid_in && req_ready_out) begin
					nxt_st = EPAS_SETUP;
					nxt_cs = ~(EPAS_CS_ONE << req_sel_in);
					nxt_addr = req_addr_in;
					nxt_wr = req_write_in;
					nxt_wdata = req_wdata_in;
				end
			end
			EPAS_SETUP: begin
				if (fall_tick) begin
					nxt_st = EPAS_STROBE;
					nxt_rd_n = wr_ff;
					nxt_wr_n = !wr_ff;
					nxt_go = 1'b0;
					nxt_wcnt = wait_mode_in[EPAS_MODE_WAIT_BIT] ? wait_states_in : EPAS_WAIT_ZERO;
				end
			end
			EPAS_STROBE: begin
				if (rise_tick && !go_ff) begin
					if (wcnt_ff != EPAS_WAIT_ZERO) begin
						nxt_wcnt = wcnt_ff - 4'h1;
					end else if (!stall_now) begin
						nxt_go = 1'b1;
					end
				end
				if (fall_tick && go_ff) begin
					nxt_st = EPAS_HOLD;
					nxt_rd_n = 1'b1;
					nxt_wr_n = 1'b1;
					if (!wr_ff) begin
						nxt_rdata = data_in;
						nxt_push = 1'b1;
					end
				end
			end
			EPAS_HOLD: begin
				if (fall_tick) begin
					nxt_st = EPAS_IDLE;
					nxt_cs = EPAS_CS_IDLE;
				end
			end
			default: begin
				nxt_st = EPAS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff <= EPAS_IDLE;
			cs_ff <= EPAS_CS_IDLE;
			addr_ff <= EPAS_ADDR_RST;
			wdata_ff <= EPAS_DATA_RST;
			rdata_ff <= EPAS_DATA_RST;
			wcnt_ff <= EPAS_WAIT_ZERO;
			wr_ff <= 1'b0;
			rd_n_ff <= 1'b1;
			wr_n_ff <= 1'b1;
			go_ff <= 1'b0;
			push_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cs_ff <= nxt_cs;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			wcnt_ff <= nxt_wcnt;
			wr_ff <= nxt_wr;
			rd_n_ff <= nxt_rd_n;
			wr_n_ff <= nxt_wr_n;
			go_ff <= nxt_go;
			push_ff <= nxt_push;
		end
	end

	// ==========================================================
	// Write data drive window
	logic oe_ff, nxt_oe;
	logic [1:0] hcnt_ff, nxt_hcnt;

	assign data_oe_out = oe_ff;

	always_comb begin
		nxt_oe = oe_ff;
		nxt_hcnt = hcnt_ff;
		if (hcnt_ff != 2'h0) begin
			nxt_hcnt = hcnt_ff - 2'h1;
			if (hcnt_ff == 2'h1) begin
				nxt_oe = 1'b0;
			end
		end else if (!wr_n_ff && !oe_ff) begin
			nxt_oe = 1'b1;
		end
		if ((st_ff == EPAS_STROBE) && fall_tick && go_ff && wr_ff) begin
			nxt_hcnt = write_hold_extend_in ? EPAS_HOLD_EXT : EPAS_HOLD_BASE;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			oe_ff <= 1'b0;
			hcnt_ff <= 2'h0;
		end else begin
			oe_ff <= nxt_oe;
			hcnt_ff <= nxt_hcnt;
		end
	end

	// ==========================================================
	// Checks
	logic [EPAS_LEN_W-1:0] slen_ff;
	logic stalled_ff;
	logic strobe_on;
	logic [EPAS_LEN_W-1:0] period_len;

	assign strobe_on = !(rd_n_ff && wr_n_ff);
	assign period_len = {1'b0, half_cnt, 1'b0};

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			slen_ff <= 6'h00;
			stalled_ff <= 1'b0;
		end else begin
			slen_ff <= strobe_on ? slen_ff + 6'h01 : 6'h00;
			if (st_ff == EPAS_SETUP) begin
				stalled_ff <= 1'b0;
			end else if ((st_ff == EPAS_STROBE) && rise_tick && !go_ff && !nxt_go) begin
				stalled_ff <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	wait_count_a: assert property ((st_ff == EPAS_STROBE) && rise_tick && !go_ff && (wcnt_ff != EPAS_WAIT_ZERO)
		|=> !go_ff && !wr_n_ff || !go_ff && !rd_n_ff)
		else $error("wait state did not hold strobe");
	ready_stall_a: assert property ((st_ff == EPAS_STROBE) && rise_tick && !go_ff && (wcnt_ff == EPAS_WAIT_ZERO)
		&& wait_mode_in[EPAS_MODE_READY_BIT] && !ready_in |=> !go_ff && (st_ff == EPAS_STROBE))
		else $error("ready low did not stall access");
	finish_two_a: assert property ((st_ff == EPAS_STROBE) && rise_tick && !go_ff && (wcnt_ff == EPAS_WAIT_ZERO)
		&& !stall_now |=> strobe_on ##[1:48] ((st_ff == EPAS_IDLE) && (cs_ff == EPAS_CS_IDLE)))
		else $error("access did not finish after ready");
	port_edges_a: assert property (!(rise_tick && fall_tick))
		else $error("port clock edges coincide");
	hold_base_a: assert property ($rose(wr_n_ff) && !$past(write_hold_extend_in)
		|-> oe_ff ##1 !oe_ff)
		else $error("base write hold wrong");
	hold_ext_a: assert property ($rose(wr_n_ff) && $past(write_hold_extend_in)
		|-> oe_ff ##1 oe_ff ##1 !oe_ff)
		else $error("extended write hold wrong");
	data_drive_a: assert property ($rose(oe_ff) |-> $past(!wr_n_ff) && !wr_n_ff)
		else $error("data driven before write strobe");
	data_release_a: assert property ($fell(oe_ff) |-> wr_n_ff)
		else $error("data released during write strobe");
	cs_wr_order_a: assert property ($fell(wr_n_ff) |-> $past(cs_ff != EPAS_CS_IDLE))
		else $error("write strobe before select");
	cs_release_a: assert property ($rose(cs_ff == EPAS_CS_IDLE) |-> $past(wr_n_ff && rd_n_ff))
		else $error("select dropped during strobe");
	addr_stable_a: assert property ($changed(addr_ff) |-> $past(rd_n_ff && wr_n_ff))
		else $error("address changed during strobe");
	strobe_edge_a: assert property (($changed(rd_n_ff) || $changed(wr_n_ff)) |-> $past(fall_tick))
		else $error("strobe moved off falling edge");
	one_cycle_a: assert property ($fell(strobe_on) && !stalled_ff |-> slen_ff == period_len)
		else $error("unstretched strobe not one port cycle");

	read_done_c: cover property ($rose(rd_n_ff) ##[1:40] (st_ff == EPAS_IDLE));
	write_done_c: cover property ($rose(wr_n_ff) ##[1:40] (st_ff == EPAS_IDLE));
	ready_stall_c: cover property (strobe_on && stalled_ff && !ready_in);
	hold_ext_c: cover property ($rose(wr_n_ff) && $past(write_hold_extend_in));

endmodule
`default_nettype wire

// >>> epas_mem_model.sv
// Behavioural external memory on the port pins
`timescale 1ns/1ns
`default_nettype none
module epas_mem_model
	import epas_pkg::*;
(
	input wire logic mclk_in, // Peripheral clock
	input wire logic rd_n_in, // Read strobe
	input wire logic wr_n_in, // Write strobe
	input wire logic [EPAS_ADDR_W-1:0] addr_in, // Address pins
	input wire logic [EPAS_DATA_W-1:0] wdata_in, // Data from port
	input wire logic wdata_oe_in, // Port drives data
	input wire logic [3:0] stall_in, // Ready low cycles
	output logic [EPAS_DATA_W-1:0] rdata_out, // Data to port
	output logic ready_out // Low to wait
);
	logic [EPAS_DATA_W-1:0] mem [int];
	bit busy = 1'b0;
	int left = 0;
	initial begin
		rdata_out = EPAS_DATA_RST;
		ready_out = 1'b1;
	end
	// ====
	// Word while read strobe low, churn otherwise
	always @(posedge mclk_in) begin
		if (!rd_n_in && mem.exists(int'(addr_in))) begin
			rdata_out <= mem[int'(addr_in)];
		end else begin
			rdata_out <= ~rdata_out;
		end
	end
	// ====
	// Wait request per access, write capture
	always @(negedge mclk_in) begin
		if (!rd_n_in || !wr_n_in) begin
			if (!busy) begin
				left = int'(stall_in);
			end
			busy = 1'b1;
		end else begin
			busy = 1'b0;
			left = 0;
		end
		ready_out <= (left == 0);
		if (left != 0) begin
			left = left - 1;
		end
		if (!wr_n_in && wdata_oe_in) begin
			mem[int'(addr_in)] = wdata_in;
		end
	end
endmodule
`default_nettype wire

// >>> epas_tb.sv
// Self-checking bench for the external port access sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench
	import epas_pkg::*;
;
	logic mclk;
	logic rst_b = 1'b0;
	logic [EPAS_DIV_W-1:0] div = '0;
	logic [1:0] mode = '0;
	logic [EPAS_WAIT_W-1:0] ws = '0;
	logic hold = 1'b0;
	logic rq_v = 1'b0;
	logic rq_w = 1'b0;
	logic [EPAS_SEL_W-1:0] sel = '0;
	logic [EPAS_ADDR_W-1:0] addr = '0;
	logic [EPAS_DATA_W-1:0] wdata = '0;
	logic rd_ready = 1'b0;
	logic [3:0] stall = '0;
	logic req_ready_out, rd_valid_out, rd_n_out, wr_n_out, data_oe_out, ready;
	logic [EPAS_DATA_W-1:0] rd_data_out, data_out, data_in;
	logic [EPAS_CS_W-1:0] memory_select_n_out;
	logic [EPAS_ADDR_W-1:0] addr_out;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int lo = 0;
	int oe_hi = 0;
	bit hold_rd = 1'b0;
	bit oe_prev = 1'b0;
	int exp_w[$];
	int exp_h[$];
	logic [EPAS_DATA_W-1:0] exp_d[$];
	logic [EPAS_DATA_W-1:0] shadow[int];
	int used[$];
	logic [EPAS_SEL_W-1:0] cur_sel = '0;
	logic [EPAS_ADDR_W-1:0] cur_addr = '0;

	epas_port_seq epas_port_seq_i (.mclk_in(mclk), .rst_b_in(rst_b), .port_div_in(div), .wait_mode_in(mode),
		.wait_states_in(ws), .write_hold_extend_in(hold), .req_valid_in(rq_v), .req_ready_out(req_ready_out),
		.req_write_in(rq_w), .req_sel_in(sel), .req_addr_in(addr), .req_wdata_in(wdata),
		.rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready), .rd_data_out(rd_data_out),
		.memory_select_n_out(memory_select_n_out), .addr_out(addr_out), .rd_n_out(rd_n_out),
		.wr_n_out(wr_n_out), .data_out(data_out), .data_oe_out(data_oe_out), .data_in(data_in),
		.ready_in(ready));
	epas_mem_model epas_mem_model_i (.mclk_in(mclk), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
		.addr_in(addr_out), .wdata_in(data_out), .wdata_oe_in(data_oe_out), .stall_in(stall),
		.rdata_out(data_in), .ready_out(ready));

	// ====
	// Checks and closing
	task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_cnt(input string what, input int e, input int g);
		chk_val(what, 32'(e), 32'(g));
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ====
	// One access with random timing set up
	task automatic access(input bit w, input int a);
		int m;
		int p;
		int n;
		n = 0;
		while (memory_select_n_out !== EPAS_CS_IDLE && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3000) bad_count++;
		div = 3'($urandom_range(3));
		mode = 2'($urandom_range(3));
		ws = 4'($urandom_range(3));
		stall = 4'($urandom_range(7));
		hold = 1'($urandom_range(1));
		sel = 2'($urandom_range(3));
		wdata = 16'($urandom);
		addr = 22'(a);
		rq_w = w;
		rq_v = 1'b1;
		p = 2 * (int'(div) + 1);
		m = mode[0] ? int'(ws) : 0;
		while (mode[1] && int'(div) + m * p < int'(stall)) begin
			m++;
		end
		exp_w.push_back(2 * int'(div) + m * p + 2);
		if (w) begin
			shadow[a] = wdata;
			exp_h.push_back(hold ? 2 : 1);
		end else begin
			exp_d.push_back(shadow[a]);
		end
		n = 0;
		while (n < 3000) begin
			#1;
			if (req_ready_out === 1'b1) break;
			@(negedge mclk);
			n++;
		end
		if (n >= 3000) bad_count++;
		cur_sel = sel;
		cur_addr = addr;
		@(negedge mclk);
		rq_v = 1'b0;
	endtask

	// ====
	// Pin watcher and reader
	always @(negedge mclk) begin
		if (rst_b) begin
			if (rd_n_out === 1'b0 || wr_n_out === 1'b0) begin
				lo++;
				chk_val("select", 32'({~(EPAS_CS_ONE << cur_sel)}), 32'(memory_select_n_out));
				chk_val("address", 32'(cur_addr), 32'(addr_out));
			end else if (lo > 0) begin
				chk_val("select after strobe", 32'h0, 32'(memory_select_n_out === EPAS_CS_IDLE));
				chk_cnt("strobe width", exp_w.pop_front(), lo);
				lo = 0;
			end
			if (data_oe_out === 1'b1 && wr_n_out === 1'b1) begin
				oe_hi++;
			end
			if (data_oe_out !== 1'b1 && oe_hi > 0) begin
				chk_cnt("write hold", exp_h.pop_front(), oe_hi);
				oe_hi = 0;
			end
			if (data_oe_out === 1'b1 && !oe_prev) begin
				chk_val("drive start", 32'h0, 32'(wr_n_out));
			end
			oe_prev = (data_oe_out === 1'b1);
			rd_ready = !hold_rd && ($urandom_range(3) != 0);
			// Word that the coming edge takes
			if (rd_valid_out === 1'b1 && rd_ready === 1'b1) begin
				chk_val("read word", 32'(exp_d.pop_front()), 32'(rd_data_out));
			end
		end
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ====
	// Main sequence
	initial begin
		int a;
		void'($urandom(72));
		repeat (5) @(negedge mclk);
		rst_b = 1'b1;
		repeat (2) @(negedge mclk);
		for (int i = 0; i < 40; i++) begin
			a = int'($urandom_range(22'h3FFFFF));
			used.push_back(a);
			access(1'b1, a);
			access(1'b0, used[$urandom_range(used.size() - 1)]);
		end
		hold_rd = 1'b1;
		fork
			repeat (4) access(1'b0, used[0]);
			begin
				repeat (300) @(negedge mclk);
				hold_rd = 1'b0;
			end
		join
		a = 0;
		while ((exp_d.size() > 0 || exp_w.size() > 0 || exp_h.size() > 0) && a < 3000) begin
			@(negedge mclk);
			a++;
		end
		if (a >= 3000) bad_count++;
		results();
	end
endmodule
`default_nettype wire
